// File: core/uart_fractional_baud_timer.sv
// fractional uart baud timer: prescaler, fractional divider, legacy baud mux
// assumes clk_sys is the core clock and all inputs come from logic on that clock
`timescale 1ns/1ps
`default_nettype none

// Operation
// [R1] with the baud source select bit set the uart ticks come from this timer and the rate double and timer 2 clock selects have no effect.
// [R2] with the baud source select bit clear the uart ticks come from timer 1 or timer 2 and the rate double flag as usual.
// [R3] control bits 6 to 3 and fraction bits 7 and 6 ignore writes and read as zero.
// [R4] control bits 2 to 0 pick the binary prescaler, codes 0 to 6 giving divider settings 0 to 6.
// [R5] the fraction register keeps a six-bit fraction in bits 5 to 0 that feeds the division.
// [R6] the control register sits at 9Eh, resets to zero and has no bit addressing.
// [R7] the fraction register sits at 9Dh, resets to zero and has no bit addressing.
// [R8] at code 6 and fraction 12h the timer gives 9600 baud from 12.58 MHz within 0.12 percent.
// [R9] the bit rate is twice the clock over two to the code minus one times fraction plus 64.
// [R10] the timer replaces timer 1 or timer 2 as baud source so those stay free.
// [R11] the output is a one-cycle tick at sixteen times the bit rate for transmit and receive.
// [R12] register writes act from the next tick period with no spurious tick, and clearing the select restarts the divider.
module uart_fractional_baud_timer (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire baud_timer_pkg::reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   input wire baud_timer_pkg::legacy_baud_t legacy_in,
   output baud_timer_pkg::baud_ticks_t ticks
);

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] frac;
      baud_timer_pkg::mode_t mode;
      logic [2:0] act_div;
      logic [5:0] act_frac;
      logic [6:0] pre_cnt;
      logic [6:0] acc;
      logic t1_half;
      logic [7:0] rdata;
      logic tx_tick;
      logic rx_tick;
   } state_t;

   state_t st_ff;
   state_t nxt_st;

   // all-ones mask of the prescaler count for a given code
   function automatic logic [6:0] prescale_mask(input logic [2:0] code);
      logic [7:0] full;
      full = (8'h01 << code) - 8'h01;
      return full[6:0];
   endfunction : prescale_mask

   logic sel;
   logic pre_en;
   logic [7:0] acc_sum;
   logic [7:0] threshold;
   logic frac_tick;
   logic t1_tick;
   logic leg_tx;
   logic leg_rx;

   always_comb begin
      sel = st_ff.ctrl[baud_timer_pkg::BAUD_SOURCE_SELECT_POS];
      pre_en = (st_ff.pre_cnt == prescale_mask(st_ff.act_div)); // [R4]
      acc_sum = {1'b0, st_ff.acc} + baud_timer_pkg::FRACTION_BASE;
      threshold = {2'b00, st_ff.act_frac} + baud_timer_pkg::FRACTION_BASE; // [R5] [R9]
      // the base weight never exceeds the threshold, so at most one tick per prescaled step
      frac_tick = (st_ff.mode == baud_timer_pkg::MODE_RUN) && pre_en
         && (acc_sum >= threshold); // [R9] [R11]
      // timer 1 path: halved unless the rate double flag is set
      t1_tick = legacy_in.timer1_ovf && (legacy_in.rate_double_flag || st_ff.t1_half); // [R2]
      leg_tx = legacy_in.tx_clock_select ? legacy_in.timer2_ovf : t1_tick; // [R2]
      leg_rx = legacy_in.rx_clock_select ? legacy_in.timer2_ovf : t1_tick; // [R2]
   end

   always_comb begin
      nxt_st = st_ff;
      // register writes; unimplemented bits never store
      if (reg_req.wr && reg_req.addr == baud_timer_pkg::BAUD_TIMER_CONTROL_ADDR) begin
         nxt_st.ctrl = reg_req.wdata & baud_timer_pkg::CONTROL_IMPL_MASK; // [R3] [R6]
      end
      if (reg_req.wr && reg_req.addr == baud_timer_pkg::BAUD_FRACTION_ADDR) begin
         nxt_st.frac = reg_req.wdata & baud_timer_pkg::FRACTION_IMPL_MASK; // [R3] [R7]
      end
      // read data one cycle later; unmapped addresses read zero
      nxt_st.rdata = 8'h00;
      if (reg_req.rd) begin
         case (reg_req.addr)
            baud_timer_pkg::BAUD_TIMER_CONTROL_ADDR: nxt_st.rdata = st_ff.ctrl; // [R6]
            baud_timer_pkg::BAUD_FRACTION_ADDR: nxt_st.rdata = st_ff.frac; // [R7]
            default: nxt_st.rdata = 8'h00;
         endcase
      end
      // legacy timer 1 halving toggle
      if (legacy_in.timer1_ovf && !legacy_in.rate_double_flag) begin
         nxt_st.t1_half = !st_ff.t1_half;
      end
      // fractional divider
      case (st_ff.mode)
         baud_timer_pkg::MODE_IDLE: begin
            nxt_st.pre_cnt = 7'h00; // [R12]
            nxt_st.acc = 7'h00; // [R12]
            if (sel) begin
               nxt_st.mode = baud_timer_pkg::MODE_RUN;
               nxt_st.act_div = st_ff.ctrl[baud_timer_pkg::PRESCALE_LSB +: baud_timer_pkg::PRESCALE_W];
               nxt_st.act_frac = st_ff.frac[baud_timer_pkg::FRACTION_LSB +: baud_timer_pkg::FRACTION_W];
            end
         end
         baud_timer_pkg::MODE_RUN: begin
            if (!sel) begin
               // restart from zero; the shadow settings reload on the next enable
               nxt_st.mode = baud_timer_pkg::MODE_IDLE;
               nxt_st.pre_cnt = 7'h00; // [R12]
               nxt_st.acc = 7'h00; // [R12]
            end else if (pre_en) begin
               nxt_st.pre_cnt = 7'h00;
               if (frac_tick) begin
                  nxt_st.acc = 7'(acc_sum - threshold); // [R9]
                  // new settings only at a tick boundary, so a period is never cut short
                  nxt_st.act_div = st_ff.ctrl[baud_timer_pkg::PRESCALE_LSB +: baud_timer_pkg::PRESCALE_W]; // [R12]
                  nxt_st.act_frac = st_ff.frac[baud_timer_pkg::FRACTION_LSB +: baud_timer_pkg::FRACTION_W]; // [R12]
               end else begin
                  nxt_st.acc = acc_sum[6:0];
               end
            end else begin
               nxt_st.pre_cnt = st_ff.pre_cnt + 7'h01;
            end
         end
         default: begin
            nxt_st.mode = baud_timer_pkg::MODE_IDLE;
         end
      endcase
      // source mux: this timer overrides both legacy selects and the rate double flag
      nxt_st.tx_tick = sel ? frac_tick : leg_tx; // [R1] [R2] [R10] [R11]
      nxt_st.rx_tick = sel ? frac_tick : leg_rx; // [R1] [R2] [R10] [R11]
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         st_ff <= '{ctrl: baud_timer_pkg::BAUD_TIMER_CONTROL_RESET,
                    frac: baud_timer_pkg::BAUD_FRACTION_RESET,
                    mode: baud_timer_pkg::MODE_IDLE,
                    default: '0}; // [R6] [R7]
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign reg_rdata = st_ff.rdata;
   assign ticks.tx_tick = st_ff.tx_tick;
   assign ticks.rx_tick = st_ff.rx_tick;

   // helper: cycles since the last tick, and whether the example setting governs the interval
   logic [7:0] gap_ff;
   logic seen_ff;

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         gap_ff <= 8'h00;
         seen_ff <= 1'b0;
      end else if (frac_tick) begin
         gap_ff <= 8'h00;
         seen_ff <= (nxt_st.act_div == baud_timer_pkg::EXAMPLE_PRESCALE)
            && (nxt_st.act_frac == baud_timer_pkg::EXAMPLE_FRACTION);
      end else begin
         if (gap_ff != 8'hFF) begin
            gap_ff <= gap_ff + 8'h01;
         end
         seen_ff <= seen_ff && sel;
      end
   end

   a_ctrl_reset_zero: assert property (@(posedge clk_sys) $rose(nrst) |-> // [R6]
      (st_ff.ctrl == 8'h00 && st_ff.frac == 8'h00 && !ticks.tx_tick))
      else $error("registers not zero after reset");

   a_ctrl_unimpl_bits: assert property (@(posedge clk_sys) disable iff (!nrst) // [R3]
      reg_req.wr && reg_req.addr == 8'h9E |=> st_ff.ctrl[6:3] == 4'h0
         && st_ff.ctrl[2:0] == $past(reg_req.wdata[2:0]))
      else $error("control write stored wrong bits");

   a_fraction_write: assert property (@(posedge clk_sys) disable iff (!nrst) // [R5]
      reg_req.wr && reg_req.addr == 8'h9D |=> st_ff.frac == {2'b00, $past(reg_req.wdata[5:0])})
      else $error("fraction write stored wrong value");

   a_read_control: assert property (@(posedge clk_sys) disable iff (!nrst) // [R6]
      reg_req.rd && reg_req.addr == 8'h9E |=> reg_rdata == $past(st_ff.ctrl))
      else $error("control read data wrong");

   a_read_unmapped: assert property (@(posedge clk_sys) disable iff (!nrst) // [R7]
      reg_req.rd && reg_req.addr != 8'h9D && reg_req.addr != 8'h9E |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");

   a_legacy_timer2: assert property (@(posedge clk_sys) disable iff (!nrst) // [R2]
      !sel && legacy_in.tx_clock_select |=> ticks.tx_tick == $past(legacy_in.timer2_ovf))
      else $error("legacy transmit tick not from timer 2");

   a_source_override: assert property (@(posedge clk_sys) disable iff (!nrst) // [R1]
      sel |=> ticks.tx_tick == ticks.rx_tick && ticks.tx_tick == $past(frac_tick))
      else $error("timer ticks not in control of the uart");

   a_restart_clear: assert property (@(posedge clk_sys) disable iff (!nrst) // [R12]
      $fell(sel) |=> st_ff.acc == 7'h00 && st_ff.pre_cnt == 7'h00 && !frac_tick)
      else $error("divider not restarted when select cleared");

   a_legacy_rx_timer2: assert property (@(posedge clk_sys) disable iff (!nrst) // [R2]
      !sel && legacy_in.rx_clock_select |=> ticks.rx_tick == $past(legacy_in.timer2_ovf))
      else $error("legacy receive tick not from timer 2");

   a_timer1_halved: assert property (@(posedge clk_sys) disable iff (!nrst) // [R2]
      !sel && !legacy_in.tx_clock_select && legacy_in.timer1_ovf
         && !legacy_in.rate_double_flag && !st_ff.t1_half |=> !ticks.tx_tick)
      else $error("timer 1 overflow not halved");

   a_settings_hold: assert property (@(posedge clk_sys) disable iff (!nrst) // [R12]
      sel && st_ff.mode == baud_timer_pkg::MODE_RUN && !frac_tick
         |=> $stable(st_ff.act_div) && $stable(st_ff.act_frac))
      else $error("divider settings changed between ticks");

   a_example_spacing: assert property (@(posedge clk_sys) disable iff (!nrst) // [R8]
      frac_tick && seen_ff |-> gap_ff == baud_timer_pkg::EXAMPLE_GAP_SHORT
         || gap_ff == baud_timer_pkg::EXAMPLE_GAP_LONG)
      else $error("tick spacing wrong for the 9600 baud setting");

endmodule : uart_fractional_baud_timer

`default_nettype wire

// File: core/baud_timer_pkg.sv
// package for the fractional uart baud timer: register map, fields, carriers
// assumes a single core clock and an 8-bit special function register port
package baud_timer_pkg;

   localparam logic [7:0] BAUD_FRACTION_ADDR = 8'h9D;
   localparam logic [7:0] BAUD_TIMER_CONTROL_ADDR = 8'h9E;
   localparam logic [7:0] BAUD_FRACTION_RESET = 8'h00;
   localparam logic [7:0] BAUD_TIMER_CONTROL_RESET = 8'h00;

   // control register fields
   localparam int BAUD_SOURCE_SELECT_POS = 7;
   localparam int PRESCALE_LSB = 0;
   localparam int PRESCALE_W = 3;
   localparam logic [7:0] CONTROL_IMPL_MASK = 8'h87;

   // fraction register fields
   localparam int FRACTION_LSB = 0;
   localparam int FRACTION_W = 6;
   localparam logic [7:0] FRACTION_IMPL_MASK = 8'h3F;

   // each prescaled step adds this weight; a tick is due once the sum reaches fraction + base
   localparam logic [7:0] FRACTION_BASE = 8'h40;

   // figures of the 9600 baud example: code 6, fraction 12h, tick spacing 64 or 128 cycles
   localparam logic [2:0] EXAMPLE_PRESCALE = 3'h6;
   localparam logic [5:0] EXAMPLE_FRACTION = 6'h12;
   localparam logic [7:0] EXAMPLE_GAP_SHORT = 8'h3F;
   localparam logic [7:0] EXAMPLE_GAP_LONG = 8'h7F;

   typedef enum logic [0:0] {
      MODE_IDLE = 1'b0,
      MODE_RUN = 1'b1
   } mode_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic timer1_ovf;
      logic timer2_ovf;
      logic rate_double_flag;
      logic tx_clock_select;
      logic rx_clock_select;
   } legacy_baud_t;

   typedef struct packed {
      logic tx_tick;
      logic rx_tick;
   } baud_ticks_t;

endpackage : baud_timer_pkg

// File: test/uart_tick_sink.sv
// partner model: uart shift logic side, consumes the 16x ticks
// assumes ticks are registered on clk_sys
`timescale 1ns/1ps
`default_nettype none
module uart_tick_sink (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire baud_timer_pkg::baud_ticks_t ticks,
   output logic [31:0] tx_count,
   output logic [31:0] rx_count
);
   // each tick is one cycle, so a plain count per edge is exact
   always @(posedge clk_sys) begin
      if (!nrst) begin
         tx_count <= 32'h0000_0000;
         rx_count <= 32'h0000_0000;
      end else begin
         tx_count <= tx_count + {31'h0, ticks.tx_tick};
         rx_count <= rx_count + {31'h0, ticks.rx_tick};
      end
   end
endmodule : uart_tick_sink
`default_nettype wire

// File: test/test_uart_fractional_baud_timer.sv
// testbench: register port, timer rates, legacy baud path
// assumes a single 200 MHz clk_sys and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module test_uart_fractional_baud_timer;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   baud_timer_pkg::reg_req_t req = '0;
   baud_timer_pkg::legacy_baud_t leg = '0;
   baud_timer_pkg::legacy_baud_t leg_rand = '0;
   baud_timer_pkg::baud_ticks_t ticks;
   logic [7:0] rdata;
   logic [7:0] v;
   logic [31:0] tx_count;
   logic [31:0] rx_count;
   logic [31:0] t0;
   logic [31:0] r0;
   logic noise = 1'b0;
   int err_count = 0;
   int check_count = 0;
   integer seed = 32'h4bed_6e3d;
   always #2.5 clk_sys = ~clk_sys;
   uart_fractional_baud_timer u_uart_fractional_baud_timer (.clk_sys(clk_sys), .nrst(nrst),
      .reg_req(req), .reg_rdata(rdata), .legacy_in(noise ? leg_rand : leg), .ticks(ticks));
   uart_tick_sink u_uart_tick_sink (.clk_sys(clk_sys), .nrst(nrst), .ticks(ticks),
      .tx_count(tx_count), .rx_count(rx_count));
   // legacy inputs toggle at random while the timer owns the rate, so leaks show up
   // a separate source keeps the directed legacy stimulus single-driven
   always @(posedge clk_sys) if (noise) leg_rand <= 5'($random(seed));
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] tol);
      check_count++;
      if ($isunknown(got) || got > exp + tol || got + tol < exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      req.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      req.rd <= 1'b0;
      #1 d = rdata;
   endtask : rd
   // ticks per window: clock over 2^code * (fraction + 64) / 64
   function automatic logic [31:0] exp_ticks(input logic [2:0] c, input logic [5:0] f);
      return 32'h0004_0000 / ((32'h0000_0001 << c) * (32'h0000_0040 + f));
   endfunction : exp_ticks
   task automatic rate(input logic [2:0] c, input logic [5:0] f);
      wr(8'h9E, 8'h00); // restart the divider
      wr(8'h9D, {2'($random(seed)), f});
      wr(8'h9E, {1'b1, 4'($random(seed)), c});
      rd(8'h9E, v);
      cmp(v, {1'b1, 4'h0, c}, 0);
      noise <= 1'b1;
      repeat (300) @(posedge clk_sys);
      t0 = tx_count;
      r0 = rx_count;
      repeat (4096) @(posedge clk_sys);
      cmp(tx_count - t0, exp_ticks(c, f), 32'h2);
      cmp(rx_count - r0, tx_count - t0, 32'h0);
      noise <= 1'b0;
      $display("rate test code %0d fraction %h done", c, f);
   endtask : rate
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : final_report
   initial begin
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      rd(8'h9E, v);
      cmp(v, 8'h00, 0);
      rd(8'h9D, v);
      cmp(v, 8'h00, 0);
      wr(8'h9E, 8'h7F);
      rd(8'h9E, v);
      cmp(v, 8'h07, 0);
      wr(8'h9D, 8'hFF);
      rd(8'h9D, v);
      cmp(v, 8'h3F, 0);
      wr(8'h9C, 8'hAA);
      rd(8'h9C, v);
      cmp(v, 8'h00, 0);
      for (int i = 0; i < 8; i++) begin
         v = 8'($random(seed));
         wr(8'h9D, v);
         rd(8'h9D, t0[7:0]);
         cmp(t0[7:0], v & 8'h3F, 0);
      end
      $display("register test done");
      wr(8'h9E, 8'h85);
      @(posedge clk_sys);
      nrst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      rd(8'h9E, v);
      cmp(v, 8'h00, 0);
      rd(8'h9D, v);
      cmp(v, 8'h00, 0);
      $display("mid-run reset test done");
      rate(3'h6, 6'h12);
      rate(3'h0, 6'h00);
      for (int c = 1; c < 8; c++) rate(3'(c), 6'($random(seed)));
      wr(8'h9E, 8'h00);
      leg <= '{timer1_ovf: 1'b0, timer2_ovf: 1'b1, rate_double_flag: 1'b1,
         tx_clock_select: 1'b1, rx_clock_select: 1'b0};
      @(posedge clk_sys);
      leg.timer2_ovf <= 1'b0;
      #1 cmp({ticks.tx_tick, ticks.rx_tick}, 2'b10, 0);
      @(posedge clk_sys);
      leg.timer1_ovf <= 1'b1;
      @(posedge clk_sys);
      leg.timer1_ovf <= 1'b0;
      #1 cmp({ticks.tx_tick, ticks.rx_tick}, 2'b01, 0);
      // without rate doubling two timer 1 overflows give exactly one tick
      repeat (2) @(posedge clk_sys);
      t0 = tx_count;
      r0 = rx_count;
      leg <= '{timer1_ovf: 1'b1, timer2_ovf: 1'b0, rate_double_flag: 1'b0,
         tx_clock_select: 1'b0, rx_clock_select: 1'b0};
      repeat (2) @(posedge clk_sys);
      leg.timer1_ovf <= 1'b0;
      repeat (3) @(posedge clk_sys);
      cmp(tx_count - t0, 32'h1, 32'h0);
      cmp(rx_count - r0, 32'h1, 32'h0);
      $display("legacy test done");
      final_report();
   end
endmodule : test_uart_fractional_baud_timer
`default_nettype wire
